// >>> rtl/srs_speed_ref.v
// Speed reference selector: analog curve, UP/DOWN trim, segment speeds and register slave
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`include "srs_map.vh"
module srs_speed_ref #(
    parameter SW          = 12,
    parameter TICK_CYCLES = `SRS_SEG_TICK_CYCLES
) (
    input  wire          ref_clk,
    input  wire          rst_n,
    input  wire [7:0]    avs_address,
    input  wire          avs_read,
    input  wire          avs_write,
    input  wire [31:0]   avs_writedata,
    input  wire [3:0]    avs_byteenable,
    output reg  [31:0]   avs_readdata,
    output wire          avs_waitrequest,
    input  wire [SW-1:0] analog_sample,
    input  wire          run_cmd,
    input  wire          fwd_rev_cmd,
    input  wire          trim_up,
    input  wire          trim_down,
    input  wire [3:0]    segment_select,
    output reg  [16:0]   freq_mag_q,
    output reg           dir_reverse_q,
    output reg           run_active_q,
    output reg           setpoint_valid_q,
    output reg  [3:0]    seg_index_q,
    output reg           accel_sel_q,
    output reg           decel_sel_q
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;
    localparam [16:0] FMAX = 17'd100000;

    reg         top_bias_direction_q;
    reg         bottom_bias_direction_q;
    reg         negative_reverse_enable_q;
    reg         trim_memory_select_q;
    reg         trim_unit_select_q;
    reg  [2:0]  segment_mode_select_q;
    reg  [7:0]  trim_multiplier_q;
    reg  [13:0] analog_top_frequency_q;
    reg  [13:0] analog_bottom_frequency_q;
    reg  [15:0] segment_direction_q;
    reg  [15:0] segment_accel_select_q;
    reg  [15:0] segment_decel_select_q;
    reg  [13:0] seg_freq_q [1:15];
    reg  [15:0] seg_time_q [0:15];
    reg  signed [18:0] trim_q;
    reg  signed [18:0] analog_sp_q;
    reg         ack_q;
    reg         run_eff_q;
    reg  [1:0]  state_q;
    reg  [3:0]  step_q;
    reg  [15:0] dwell_q;
    reg  [31:0] tick_cnt_q;
    reg         tick_q;

    // Returns the first segment at or after start, wrapping from 15 to 0, whose duration is non-zero
    function [4:0] first_live;
        input [15:0] live;
        input [3:0]  start;
        integer      k;
        reg   [3:0]  idx;
        reg          found;
        begin
            found = 1'b0;
            idx   = 4'h0;
            for (k = 0; k < 16; k = k + 1) begin
                if (!found && live[4'(start + k[3:0])]) begin
                    found = 1'b1;
                    idx   = 4'(start + k[3:0]);
                end
            end
            first_live = {found, idx};
        end
    endfunction

    // Clamps a written frequency to the settable range
    function [13:0] clamp_freq;
        input [31:0] v;
        begin
            clamp_freq = (v[31:14] != 18'h0 || v[13:0] > `SRS_FREQ_MAX) ? `SRS_FREQ_MAX : v[13:0];
        end
    endfunction

    wire [15:0] live;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_live
            assign live[gi] = seg_time_q[gi] != 16'h0000; // [R14]
        end
    endgenerate

    // Register slave
    wire [5:0] widx   = avs_address[7:2];
    wire       wr_go  = avs_write && !ack_q && avs_byteenable == 4'hF;
    wire       is_tab_f = widx[5:4] == 2'b01 && widx[3:0] != 4'h0;
    wire       is_tab_t = widx[5:4] == 2'b10;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    integer i;
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            top_bias_direction_q      <= 1'b0;
            bottom_bias_direction_q   <= 1'b0;
            negative_reverse_enable_q <= 1'b0;
            trim_memory_select_q      <= 1'b0;
            trim_unit_select_q        <= 1'b0;
            segment_mode_select_q     <= `SRS_MODE_RESET;
            trim_multiplier_q         <= `SRS_MULT_RESET;
            analog_top_frequency_q    <= `SRS_TOP_RESET;
            analog_bottom_frequency_q <= `SRS_BOTTOM_RESET;
            segment_direction_q       <= 16'h0000;
            segment_accel_select_q    <= 16'h0000;
            segment_decel_select_q    <= 16'h0000;
            for (i = 1; i < 16; i = i + 1) begin
                seg_freq_q[i] <= 14'h0000;
            end
            for (i = 0; i < 16; i = i + 1) begin
                seg_time_q[i] <= 16'h0000;
            end
        end else if (wr_go) begin
            if (is_tab_f) begin
                seg_freq_q[widx[3:0]] <= clamp_freq(avs_writedata);
            end else if (is_tab_t) begin
                seg_time_q[widx[3:0]] <= avs_writedata[15:0];
            end else begin
                case (widx)
                    `SRS_OFS_CTRL: begin
                        top_bias_direction_q      <= avs_writedata[`SRS_CTRL_TOP_DIR]; // [R3]
                        bottom_bias_direction_q   <= avs_writedata[`SRS_CTRL_BOT_DIR]; // [R3]
                        negative_reverse_enable_q <= avs_writedata[`SRS_CTRL_NEG_REV]; // [R4]
                        trim_memory_select_q      <= avs_writedata[`SRS_CTRL_TRIM_MEM]; // [R8]
                        trim_unit_select_q        <= avs_writedata[`SRS_CTRL_TRIM_UNIT]; // [R9]
                        // Out-of-range mode codes leave the mode unchanged
                        if (avs_writedata[`SRS_CTRL_MODE_LSB+2:`SRS_CTRL_MODE_LSB] <= `SRS_MODE_MAX) begin
                            segment_mode_select_q <= avs_writedata[`SRS_CTRL_MODE_LSB+2:`SRS_CTRL_MODE_LSB]; // [R11]
                        end
                        if (avs_writedata[`SRS_CTRL_MULT_LSB+7:`SRS_CTRL_MULT_LSB] < `SRS_MULT_MIN) begin
                            trim_multiplier_q <= `SRS_MULT_MIN; // [R10]
                        end else if (avs_writedata[`SRS_CTRL_MULT_LSB+7:`SRS_CTRL_MULT_LSB] > `SRS_MULT_MAX) begin
                            trim_multiplier_q <= `SRS_MULT_MAX; // [R10]
                        end else begin
                            trim_multiplier_q <= avs_writedata[`SRS_CTRL_MULT_LSB+7:`SRS_CTRL_MULT_LSB];
                        end
                    end
                    `SRS_OFS_TOP:       analog_top_frequency_q    <= clamp_freq(avs_writedata); // [R1]
                    `SRS_OFS_BOTTOM:    analog_bottom_frequency_q <= clamp_freq(avs_writedata); // [R2]
                    `SRS_OFS_SEG_DIR:   segment_direction_q       <= avs_writedata[15:0];
                    `SRS_OFS_SEG_ACCEL: segment_accel_select_q    <= avs_writedata[15:0];
                    `SRS_OFS_SEG_DECEL: segment_decel_select_q    <= avs_writedata[15:0];
                    default: ;
                endcase
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            if (is_tab_f) begin
                avs_readdata <= {18'h0, seg_freq_q[widx[3:0]]};
            end else if (is_tab_t) begin
                avs_readdata <= {16'h0, seg_time_q[widx[3:0]]};
            end else begin
                case (widx)
                    `SRS_OFS_CTRL: avs_readdata <= {8'h0, trim_multiplier_q, 5'h0, segment_mode_select_q,
                                                    3'h0, trim_unit_select_q, trim_memory_select_q,
                                                    negative_reverse_enable_q, bottom_bias_direction_q,
                                                    top_bias_direction_q};
                    `SRS_OFS_TOP:       avs_readdata <= {18'h0, analog_top_frequency_q};
                    `SRS_OFS_BOTTOM:    avs_readdata <= {18'h0, analog_bottom_frequency_q};
                    `SRS_OFS_SEG_DIR:   avs_readdata <= {16'h0, segment_direction_q};
                    `SRS_OFS_SEG_ACCEL: avs_readdata <= {16'h0, segment_accel_select_q};
                    `SRS_OFS_SEG_DECEL: avs_readdata <= {16'h0, segment_decel_select_q};
                    `SRS_OFS_STATUS:    avs_readdata <= {24'h0, state_q[1], setpoint_valid_q, dir_reverse_q,
                                                         run_active_q, seg_index_q};
                    `SRS_OFS_SETPOINT:  avs_readdata <= {15'h0, freq_mag_q};
                    `SRS_OFS_TRIM:      avs_readdata <= {{13{trim_q[18]}}, trim_q};
                    default:            avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Analog curve: end-points are scaled to 0.01 Hz and signed by their bias bits
    wire [17:0] top_hund = 18'(analog_top_frequency_q * 4'd10);
    wire [17:0] bot_hund = 18'(analog_bottom_frequency_q * 4'd10);
    wire signed [17:0] top_signed = top_bias_direction_q ? -$signed(top_hund) : $signed(top_hund); // [R3]
    wire signed [17:0] bot_signed = bottom_bias_direction_q ? -$signed(bot_hund) : $signed(bot_hund); // [R3]
    wire               interp_busy;
    wire               interp_done;
    wire signed [18:0] interp_result;

    // Runs back to back so a new sample or setting shows by the end of the next conversion
    srs_interp #(.SW(SW)) u_interp (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .start    (!interp_busy), // [R19]
        .low_end  (bot_signed), // [R7]
        .high_end (top_signed), // [R7]
        .sample   (analog_sample),
        .busy     (interp_busy),
        .done_q   (interp_done),
        .result_q (interp_result)
    );

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            analog_sp_q <= 19'sh0;
        end else if (interp_done) begin
            analog_sp_q <= interp_result; // [R19]
        end
    end

    // Run and trim
    wire auto_run = segment_mode_select_q == `SRS_MODE_EXT4_AUTO ||
                    segment_mode_select_q == `SRS_MODE_EXT16_AUTO;
    wire run_eff  = run_cmd || auto_run; // [R12]
    wire [11:0] trim_step = 12'(trim_multiplier_q * (trim_unit_select_q ? 4'd10 : 4'd1)); // [R9] [R10]
    wire signed [19:0] trim_up_v = {trim_q[18], trim_q} + $signed({8'h0, trim_step});
    wire signed [19:0] trim_dn_v = {trim_q[18], trim_q} - $signed({8'h0, trim_step});

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            trim_q    <= 19'sh0;
            run_eff_q <= 1'b0;
        end else begin
            run_eff_q <= run_eff;
            if (run_eff_q && !run_eff && !trim_memory_select_q) begin
                trim_q <= 19'sh0; // [R8]
            end else if (trim_up && !trim_down && trim_up_v <= $signed({3'h0, FMAX})) begin
                trim_q <= trim_up_v[18:0]; // [R19]
            end else if (trim_down && !trim_up && trim_dn_v >= -$signed({3'h0, FMAX})) begin
                trim_q <= trim_dn_v[18:0]; // [R19]
            end
        end
    end

    // Segment time base, one enable pulse per tick
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b0;
        end else begin
            tick_q <= tick_cnt_q == 32'(TICK_CYCLES - 1);
            tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
        end
    end

    // Internal sequencer
    wire       internal = segment_mode_select_q == `SRS_MODE_INTERNAL;
    wire [4:0] first_seg = first_live(live, 4'h0);
    wire [4:0] next_seg  = first_live(live, 4'(step_q + 4'h1));

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            step_q  <= 4'h0;
            dwell_q <= 16'h0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (internal && run_eff && first_seg[4]) begin
                        state_q <= ST_RUN;
                        step_q  <= first_seg[3:0]; // [R13]
                        dwell_q <= 16'h0000;
                    end
                end
                ST_RUN: begin
                    if (!internal || !run_eff || !live[step_q]) begin
                        state_q <= ST_IDLE;
                    end else if (tick_q) begin
                        // Durations come only from stored settings
                        if (dwell_q + 16'h0001 >= seg_time_q[step_q]) begin // [R15]
                            step_q  <= next_seg[3:0]; // [R13] [R14]
                            dwell_q <= 16'h0000;
                        end else begin
                            dwell_q <= dwell_q + 16'h0001;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Setpoint selection
    reg  [3:0]         sel_d;
    reg                use_analog_d;
    reg  signed [19:0] raw_d;
    reg                rev_d;
    reg                valid_d;
    reg  [16:0]        mag_d;
    always @* begin
        sel_d        = 4'h0;
        use_analog_d = 1'b0;
        case (segment_mode_select_q)
            `SRS_MODE_INTERNAL:                      sel_d = step_q;
            `SRS_MODE_EXT4, `SRS_MODE_EXT4_AUTO:     sel_d = {2'b00, segment_select[1:0]};
            `SRS_MODE_EXT16, `SRS_MODE_EXT16_AUTO:   sel_d = segment_select; // [R17] [R18]
            default:                                 use_analog_d = 1'b1;
        endcase
        if (use_analog_d || sel_d == 4'h0) begin
            raw_d = {analog_sp_q[18], analog_sp_q} + {trim_q[18], trim_q}; // [R17]
        end else begin
            raw_d = $signed({3'h0, 17'(seg_freq_q[sel_d] * 4'd10)}) + {trim_q[18], trim_q}; // [R18]
        end
        valid_d = 1'b1;
        rev_d   = 1'b0;
        mag_d   = 17'h0_0000;
        if (raw_d < 0) begin
            if (negative_reverse_enable_q || !use_analog_d && sel_d != 4'h0) begin
                rev_d = 1'b1; // [R4]
                mag_d = (-raw_d > $signed({3'h0, FMAX})) ? FMAX : 17'(-raw_d); // [R4]
            end else begin
                valid_d = 1'b0; // [R6]
            end
        end else begin
            mag_d = (raw_d > $signed({3'h0, FMAX})) ? FMAX : raw_d[16:0];
        end
        if (internal) begin
            rev_d = segment_direction_q[step_q]; // [R15] [R16]
        end else begin
            rev_d = rev_d ^ fwd_rev_cmd; // [R5]
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            freq_mag_q       <= 17'h0_0000;
            dir_reverse_q    <= 1'b0;
            run_active_q     <= 1'b0;
            setpoint_valid_q <= 1'b0;
            seg_index_q      <= 4'h0;
            accel_sel_q      <= 1'b0;
            decel_sel_q      <= 1'b0;
        end else begin
            seg_index_q      <= internal ? step_q : sel_d;
            setpoint_valid_q <= valid_d;
            dir_reverse_q    <= rev_d;
            run_active_q     <= internal ? state_q == ST_RUN : run_eff && valid_d; // [R12]
            freq_mag_q       <= valid_d ? mag_d : 17'h0_0000; // [R6]
            accel_sel_q      <= internal && segment_accel_select_q[step_q]; // [R16]
            decel_sel_q      <= internal && segment_decel_select_q[step_q]; // [R16]
        end
    end
endmodule // srs_speed_ref

// >>> rtl/srs_map.vh
// Register map, field layout, reset values and timing constants of the speed reference selector
// Overview of operation
// R1: High-end analog frequency, 0.0 to 1000.0 Hz in 0.1 Hz, default 50.0 Hz.
// R2: Low-end analog frequency, same range and resolution, default 0.0 Hz.
// R3: Each end-point has a bias bit: 0 forward, 1 reverse.
// R4: Reverse enable: 0 never reverse on negative setpoint, 1 reverse at its magnitude. The code reverses a negative segment setpoint at either setting.
// R5: Forward/reverse terminal still inverts the direction produced by the analog curve.
// R6: Reverse disabled: negative mapped setpoints are invalid and give no running frequency.
// R7: Setpoint is linear between signed low end and signed high end.
// R8: Trim memory: 0 discards trim on stop, 1 keeps it for restart.
// R9: Trim unit: 0 gives 0.01 Hz per step, 1 gives 0.1 Hz.
// R10: Trim step is the unit times a multiplier of 1 to 250.
// R11: Segment mode 0 to 5, default 2, picks normal, internal or external modes.
// R12: Modes 4 and 5 behave as if a run command were present.
// R13: Internal mode sequences sixteen speeds: main speed then fifteen segment speeds.
// R14: Software sets the duration of every unused segment to zero to skip it.
// R15: Internal mode uses stored durations and directions only, ignoring terminals.
// R16: Internal mode takes direction and ramp choice from per-segment bits.
// R17: External 16-segment mode decodes four selects; all-off picks main frequency.
// R18: Code 1 picks the first segment frequency, higher codes ascend in order.
// R19: Setpoint is re-evaluated on any select, trim or sample change without restart.
`ifndef SRS_MAP_VH
`define SRS_MAP_VH
`define SRS_OFS_CTRL       6'h00
`define SRS_OFS_TOP        6'h01
`define SRS_OFS_BOTTOM     6'h02
`define SRS_OFS_SEG_DIR    6'h03
`define SRS_OFS_SEG_ACCEL  6'h04
`define SRS_OFS_SEG_DECEL  6'h05
`define SRS_OFS_STATUS     6'h06
`define SRS_OFS_SETPOINT   6'h07
`define SRS_OFS_TRIM       6'h08
`define SRS_OFS_FREQ_BASE  6'h10
`define SRS_OFS_TIME_BASE  6'h20
`define SRS_CTRL_TOP_DIR   0
`define SRS_CTRL_BOT_DIR   1
`define SRS_CTRL_NEG_REV   2
`define SRS_CTRL_TRIM_MEM  3
`define SRS_CTRL_TRIM_UNIT 4
`define SRS_CTRL_MODE_LSB  8
`define SRS_CTRL_MULT_LSB  16
`define SRS_TOP_RESET      14'h01F4
`define SRS_BOTTOM_RESET   14'h0000
`define SRS_FREQ_MAX       14'h2710
`define SRS_MODE_RESET     3'h2
`define SRS_MODE_MAX       3'h5
`define SRS_MULT_RESET     8'h01
`define SRS_MULT_MIN       8'h01
`define SRS_MULT_MAX       8'hFA
`define SRS_MODE_NORMAL    3'h0
`define SRS_MODE_INTERNAL  3'h1
`define SRS_MODE_EXT4      3'h2
`define SRS_MODE_EXT16     3'h3
`define SRS_MODE_EXT4_AUTO 3'h4
`define SRS_MODE_EXT16_AUTO 3'h5
`define SRS_ADC_FULL       13'h0FFF
`define SRS_CLK_HZ         100000000
`define SRS_SEG_TICK_MS    100
`define SRS_SEG_TICK_CYCLES (`SRS_SEG_TICK_MS * (`SRS_CLK_HZ / 1000))
`endif

// >>> rtl/srs_interp.v
// Linear interpolation between two signed end-points, serial divider
`include "srs_map.vh"
module srs_interp #(
    parameter SW = 12
) (
    input  wire                ref_clk,
    input  wire                rst_n,
    input  wire                start,
    input  wire signed [17:0]  low_end,
    input  wire signed [17:0]  high_end,
    input  wire [SW-1:0]       sample,
    output wire                busy,
    output reg                 done_q,
    output reg  signed [18:0]  result_q
);
    reg  [30:0]        num_q;
    reg  [12:0]        rem_q;
    reg  [4:0]         cnt_q;
    reg                busy_q;
    reg                neg_q;
    reg  signed [17:0] base_q;
    wire signed [18:0] diff = {high_end[17], high_end} - {low_end[17], low_end};
    wire signed [32:0] prod = diff * $signed({1'b0, sample});
    wire [31:0]        mag  = prod[32] ? 32'(-prod) : prod[31:0];
    wire [13:0]        trial = {rem_q, num_q[30]};
    wire               fits  = trial >= {1'b0, `SRS_ADC_FULL};
    // Last quotient bit comes from this cycle's trial
    wire [17:0]        quot  = {num_q[16:0], fits};

    assign busy = busy_q;

    // Division by full scale is done bit-serially to avoid a wide constant divider
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            cnt_q    <= 5'h00;
            num_q    <= 31'h0;
            rem_q    <= 13'h0000;
            neg_q    <= 1'b0;
            base_q   <= 18'sh0;
            result_q <= 19'sh0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin // [R7]
                busy_q <= 1'b1;
                cnt_q  <= 5'h1E;
                num_q  <= mag[30:0];
                rem_q  <= 13'h0000;
                neg_q  <= prod[32];
                base_q <= low_end;
            end else if (busy_q) begin
                rem_q <= fits ? 13'(trial - {1'b0, `SRS_ADC_FULL}) : trial[12:0];
                num_q <= {num_q[29:0], fits};
                if (cnt_q == 5'h00) begin
                    busy_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - 5'h01;
                end
            end
            if (busy_q && cnt_q == 5'h00) begin
                done_q   <= 1'b1;
                result_q <= neg_q ? 19'({base_q[17], base_q} - $signed({1'b0, quot}))
                                  : 19'({base_q[17], base_q} + $signed({1'b0, quot}));
            end
        end
    end
endmodule // srs_interp

// >>> dv/srs_properties.sv
// Bus handshake and setpoint checks for the speed reference selector
module srs_properties (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [16:0] freq_mag_q,
    input wire logic        run_active_q,
    input wire logic        setpoint_valid_q
);
    timeunit 1ns / 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_req_waits: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("new request not held off");
    a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("second wait cycle");
    a_wait_bound: assert property (avs_read |-> ##[0:1] !avs_waitrequest)
        else $error("read not answered");
    a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait raised while idle");
    // Read data must stand until the next read is taken
    a_readdata_hold: assert property (!$past(avs_read && avs_waitrequest) |-> $stable(avs_readdata))
        else $error("read data moved without a read");
    a_reset_quiet: assert property ($rose(rst_n) |-> freq_mag_q == 17'h0_0000 && !run_active_q)
        else $error("outputs not cleared by reset");
    a_invalid_zero: assert property (!setpoint_valid_q |-> freq_mag_q == 17'h0_0000)
        else $error("frequency given for invalid setpoint");
    a_freq_ceiling: assert property (freq_mag_q <= 17'h1_86A0)
        else $error("frequency above ceiling");
endmodule // srs_properties

bind srs_speed_ref srs_properties chk (.ref_clk, .rst_n, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .freq_mag_q, .run_active_q, .setpoint_valid_q);

// >>> dv/srs_terminal_model.sv
// Terminal wiring and analog source facing the speed reference selector
module srs_terminal_model (
    input  wire logic        ref_clk,
    input  wire logic [11:0] level,
    input  wire logic        up_req,
    input  wire logic        dn_req,
    output var  logic [11:0] analog_sample = 12'h000,
    output var  logic        trim_up = 1'b0,
    output var  logic        trim_down = 1'b0
);
    timeunit 1ns / 1ps;
    // One register stage, so commands reach the pins an edge late
    always @(posedge ref_clk) begin
        analog_sample <= level;
        trim_up <= up_req;
        trim_down <= dn_req;
    end
endmodule // srs_terminal_model

// >>> dv/test_speed_reference_select.sv
// Self-checking bench for the speed reference selector
module test_speed_reference_select;
    timeunit 1ns / 1ps;
    logic        ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, up_req = 0, dn_req = 0;
    logic        run_cmd = 0, fwd_rev_cmd = 0, avs_waitrequest, trim_up, trim_down;
    logic        dir_reverse_q, run_active_q, setpoint_valid_q, accel_sel_q, decel_sel_q;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
    logic [11:0] level = 12'h000, analog_sample;
    logic [3:0]  segment_select = 4'h0, seg_index_q;
    logic [16:0] freq_mag_q;
    int          fail_count = 0, n_checks = 0;
    // Short segment tick keeps sequences brief
    srs_speed_ref #(.SW(12), .TICK_CYCLES(20)) dut (.*, .avs_byteenable(4'hF));
    srs_terminal_model model (.*);
    initial forever #5 ref_clk = ~ref_clk;
    task complete_run;
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(negedge ref_clk); while (avs_waitrequest !== 1'b0);
        @(posedge ref_clk);
        if (!wr) check(avs_readdata, exp);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    // A conversion takes 32 cycles
    task expect_out(input logic [16:0] f, input logic d, input logic v, input logic [3:0] k);
        repeat (40) @(negedge ref_clk);
        repeat (300) if ({freq_mag_q, setpoint_valid_q} !== {f, v}) @(negedge ref_clk);
        check(freq_mag_q, f);
        check(setpoint_valid_q, v);
        check(seg_index_q, k);
        if (v) check(dir_reverse_q, d);
        @(posedge ref_clk);
    endtask
    task pulse(input logic up);
        up_req <= up;
        dn_req <= !up;
        @(posedge ref_clk);
        up_req <= 1'b0;
        dn_req <= 1'b0;
    endtask
    task restart;
        run_cmd <= 1'b0;
        repeat (3) @(posedge ref_clk);
        run_cmd <= 1'b1;
    endtask
    task t_curve;
        bus(0, 8'h00, '0, 32'h0001_0200);
        bus(0, 8'h04, '0, 32'h0000_01F4);
        bus(0, 8'hC0, '0, 32'h0000_0000);
        bus(1, 8'h00, 32'h0000_0600, '0);
        bus(0, 8'h00, '0, 32'h0001_0200);
        bus(1, 8'h00, 32'h0001_0000, '0);
        run_cmd <= 1'b1;
        level <= 12'hFFF;
        expect_out(17'h0_1388, 0, 1, 0);
        level <= 12'h800;
        expect_out(17'h0_09C4, 0, 1, 0);
        level <= 12'h000;
        bus(1, 8'h08, 32'h0000_01F4, '0);
        bus(1, 8'h00, 32'h0001_0002, '0);
        expect_out(17'h0_0000, 0, 0, 0);
        bus(1, 8'h00, 32'h0001_0006, '0);
        expect_out(17'h0_1388, 1, 1, 0);
        fwd_rev_cmd <= 1'b1;
        expect_out(17'h0_1388, 0, 1, 0);
        fwd_rev_cmd <= 1'b0;
        bus(1, 8'h08, '0, '0);
    endtask
    task t_trim;
        level <= 12'hFFF;
        bus(1, 8'h00, 32'h0003_0010, '0);
        pulse(1);
        expect_out(17'h0_13A6, 0, 1, 0);
        restart;
        expect_out(17'h0_1388, 0, 1, 0);
        bus(1, 8'h00, 32'h00FA_0008, '0);
        pulse(1);
        expect_out(17'h0_1482, 0, 1, 0);
        restart;
        expect_out(17'h0_1482, 0, 1, 0);
        pulse(0);
        expect_out(17'h0_1388, 0, 1, 0);
    endtask
    task t_seg;
        for (int k = 1; k < 16; k++) bus(1, 8'h40 + 8'(4 * k), 32'(10 * k), '0);
        bus(1, 8'h00, 32'h0001_0300, '0);
        for (int k = 0; k < 16; k++) begin
            segment_select <= 4'(k);
            expect_out(k ? 17'(100 * k) : 17'h0_1388, 0, 1, 4'(k));
        end
        run_cmd <= 1'b0;
        bus(1, 8'h00, 32'h0001_0400, '0);
        segment_select <= 4'h6;
        expect_out(17'h0_00C8, 0, 1, 2);
        check(run_active_q, 1);
        bus(1, 8'h00, 32'h0001_0500, '0);
        expect_out(17'h0_0258, 0, 1, 6);
        check(run_active_q, 1);
    endtask
    task t_int;
        for (int i = 0; i < 16; i++) bus(1, 8'h80 + 8'(4 * i), (i == 1) ? 32'h0000_0002 : 32'(i == 3), '0);
        bus(1, 8'h0C, 32'h0000_0008, '0);
        bus(1, 8'h10, 32'h0000_0008, '0);
        bus(1, 8'h14, 32'h0000_0002, '0);
        bus(1, 8'h00, 32'h0001_0100, '0);
        fwd_rev_cmd <= 1'b1;
        run_cmd <= 1'b1;
        repeat (300) if (seg_index_q !== 4'h3) @(negedge ref_clk);
        check(freq_mag_q, 17'h0_012C);
        check(dir_reverse_q, 1);
        check({accel_sel_q, decel_sel_q}, 2'b10);
        repeat (300) if (seg_index_q !== 4'h1) @(negedge ref_clk);
        check(freq_mag_q, 17'h0_0064);
        check(dir_reverse_q, 0);
        check({accel_sel_q, decel_sel_q}, 2'b01);
    endtask
    initial begin
        #500us;
        fail_count++;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_curve;
        t_trim;
        t_seg;
        t_int;
        complete_run;
    end
endmodule // test_speed_reference_select
